//--- hdl/smbc_top.v
// Supply monitor, thermal shutdown and three-buck control with an Avalon-MM slave.
// Assumes comparator and power-good inputs already synchronous to ref_clk_i.
// Assumes software toggles a buck's on bit to start or stop it.
`timescale 1ns/1ps
`include "smbc_consts.vh"

module smbc_top #(
  parameter NBUCK    = 3,
  parameter UNIT_CYC = `SMBC_DLY_UNIT_CYC
) (
  // Clock and reset
  input  wire              ref_clk_i,
  input  wire              rst_n_i,
  // Avalon-MM slave
  input  wire [3:0]        avs_address_i,
  input  wire              avs_read_i,
  input  wire              avs_write_i,
  input  wire [31:0]       avs_writedata_i,
  input  wire [3:0]        avs_byteenable_i,
  output reg  [31:0]       avs_readdata_o,
  output wire              avs_waitrequest_o,
  // Analog monitors
  input  wire              monitored_supply_low_i,
  input  wire              over_temp_i,
  input  wire [NBUCK-1:0]  buck_pgood_i,
  // Regulator controls
  output wire [NBUCK-1:0]  buck_enable_o,
  output wire [NBUCK-1:0]  buck_force_pwm_o,
  output wire [6*NBUCK-1:0] output_voltage_code_o,
  output wire [3:0]        supply_threshold_select_o,
  // Interrupt pin, open drain
  output wire              irq_out_n_o,
  output wire              irq_out_n_oe_o
);

  // One-wait-cycle answer: acknowledge on second cycle of an access
  reg         ack;
  wire        req = (avs_read_i | avs_write_i) & ~ack;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack <= 1'b0;
    end else begin
      ack <= req;
    end
  end

  wire        acc_wr = avs_write_i & ack & avs_byteenable_i[0];
  wire        acc_rd = avs_read_i & ack;
  wire [1:0]  sel_buck = avs_address_i[3:2] - 2'h1;
  wire        is_buck = (avs_address_i[3:2] != 2'h0) && (sel_buck < NBUCK);

  // System register
  reg  [3:0]  supply_threshold_select;
  reg         undervoltage_response_mode;
  reg         supply_level_irq_mask;
  reg         supply_irq;
  reg         supply_low_d;
  reg         shutdown;

  assign supply_threshold_select_o = supply_threshold_select;

  wire supply_fall = monitored_supply_low_i & ~supply_low_d;
  wire stat_read = acc_rd && (avs_address_i == `SMBC_ADDR_STAT);

  // System register fields
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      supply_threshold_select    <= 4'h7;
      undervoltage_response_mode <= 1'b1;
      supply_level_irq_mask      <= 1'b0;
    end else begin
      if (acc_wr && avs_address_i == `SMBC_ADDR_SYS) begin
        supply_threshold_select    <= avs_writedata_i[`SMBC_SYS_LEV_LSB+3:`SMBC_SYS_LEV_LSB];
        undervoltage_response_mode <= avs_writedata_i[`SMBC_SYS_MODE_BIT];
        supply_level_irq_mask      <= avs_writedata_i[`SMBC_SYS_MSK_BIT];
      end
    end
  end

  // Supply interrupt; set wins over read-clear
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      supply_irq   <= 1'b0;
      supply_low_d <= 1'b0;
    end else begin
      supply_low_d <= monitored_supply_low_i;
      if (supply_fall && undervoltage_response_mode && supply_level_irq_mask) begin
        supply_irq <= 1'b1;
      end else if (stat_read && !monitored_supply_low_i) begin
        supply_irq <= 1'b0;
      end
    end
  end

  // Forces all bucks off: one-cycle pulse on supply fall when undervoltage_response_mode is 0, held high while over_temp_i is high
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shutdown <= 1'b0;
    end else begin
      shutdown <= (supply_fall & ~undervoltage_response_mode) | over_temp_i;
    end
  end

  // Per-buck logic
  wire [NBUCK-1:0]   on_bit;
  wire [NBUCK-1:0]   en;
  wire [NBUCK-1:0]   mode;
  wire [NBUCK-1:0]   fmask;
  wire [NBUCK-1:0]   fault_irq;
  wire [3*NBUCK-1:0] dly;
  wire [6*NBUCK-1:0] vcode;
  // Protection also drops any start still counting
  wire               kill     = shutdown | over_temp_i;
  wire               acc_ctl  = acc_wr && is_buck && (avs_address_i[1:0] == 2'h0);
  wire               acc_vout = acc_wr && is_buck && (avs_address_i[1:0] == 2'h1);
  wire               acc_bst  = acc_rd && is_buck && (avs_address_i[1:0] == 2'h2);

  assign buck_enable_o         = en;
  assign buck_force_pwm_o      = mode;
  assign output_voltage_code_o = vcode;

  genvar g;
  generate
    for (g = 0; g < NBUCK; g = g + 1) begin : g_buck
      smbc_buck_slot #(
        .UNIT_CYC    (UNIT_CYC)
      ) i_slot (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .ctl_wr_i    (acc_ctl && (sel_buck == g)),
        .vout_wr_i   (acc_vout && (sel_buck == g)),
        .stat_rd_i   (acc_bst && (sel_buck == g)),
        .wdata_i     (avs_writedata_i),
        .kill_i      (kill),
        .pgood_i     (buck_pgood_i[g]),
        .on_bit_o    (on_bit[g]),
        .dly_o       (dly[3*g +: 3]),
        .mode_o      (mode[g]),
        .fmask_o     (fmask[g]),
        .vcode_o     (vcode[6*g +: 6]),
        .en_o        (en[g]),
        .fault_irq_o (fault_irq[g])
      );
    end
  endgenerate

  wire irq_any = supply_irq | (|fault_irq);
  assign irq_out_n_o    = 1'b0;
  assign irq_out_n_oe_o = ~irq_any;

  // Read mux; unmapped words read zero
  reg [31:0] next_readdata;

  always @* begin
    next_readdata = 32'h0;
    case (avs_address_i)
      `SMBC_ADDR_SYS: begin
        next_readdata[5:0] = {supply_level_irq_mask, undervoltage_response_mode,
                              supply_threshold_select};
      end
      `SMBC_ADDR_STAT: begin
        next_readdata[2:0] = {over_temp_i, supply_irq, monitored_supply_low_i};
      end
      default: begin
        if (is_buck) begin
          case (avs_address_i[1:0])
            2'h0: begin
              next_readdata[5:0] = {fmask[sel_buck], mode[sel_buck],
                                    dly[3*sel_buck +: 3], on_bit[sel_buck]};
            end
            2'h1: begin
              next_readdata[5:0] = vcode[6*sel_buck +: 6];
            end
            2'h2: begin
              next_readdata[2:0] = {en[sel_buck], fault_irq[sel_buck],
                                    buck_pgood_i[sel_buck]};
            end
            default: begin
              next_readdata = 32'h0;
            end
          endcase
        end
      end
    endcase
  end

  // Loaded in the wait cycle so it stands when waitrequest drops
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0;
    end else if (req && avs_read_i) begin
      avs_readdata_o <= next_readdata;
    end
  end

endmodule // smbc_top

// One step-down channel: control fields, edge-driven enable with delay, fault flag.
module smbc_buck_slot #(
  parameter UNIT_CYC = `SMBC_DLY_UNIT_CYC
) (
  // Clock and reset
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  // Register strobes for this channel
  input  wire        ctl_wr_i,
  input  wire        vout_wr_i,
  input  wire        stat_rd_i,
  input  wire [31:0] wdata_i,
  // Protection and feedback
  input  wire        kill_i,
  input  wire        pgood_i,
  // Control fields
  output reg         on_bit_o,
  output reg  [2:0]  dly_o,
  output reg         mode_o,
  output reg         fmask_o,
  output reg  [5:0]  vcode_o,
  // Status
  output reg         en_o,
  output reg         fault_irq_o
);

  reg         on_prev;
  reg         pending;
  reg         pgood_d;
  reg  [31:0] cnt;

  wire        on_rise = on_bit_o & ~on_prev;
  wire        on_fall = ~on_bit_o & on_prev;
  wire        pg_fall = pgood_d & ~pgood_i;

  // Delay in clock cycles for a 3-bit code
  function [31:0] dly_cycles;
    input [2:0] code;
    begin
      if (code == 3'h0) begin
        dly_cycles = 32'h0;
      end else begin
        dly_cycles = UNIT_CYC << (code - 3'h1);
      end
    end
  endfunction

  // Control fields
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_bit_o <= 1'b0;
      dly_o    <= 3'h0;
      mode_o   <= 1'b0;
      fmask_o  <= 1'b0;
      vcode_o  <= `SMBC_VOUT_RESET;
    end else begin
      if (ctl_wr_i) begin
        on_bit_o <= wdata_i[`SMBC_CTL_ON_BIT];
        dly_o    <= wdata_i[`SMBC_CTL_DLY_LSB+2:`SMBC_CTL_DLY_LSB];
        mode_o   <= wdata_i[`SMBC_CTL_MODE_BIT];
        fmask_o  <= wdata_i[`SMBC_CTL_MSK_BIT];
      end
      if (vout_wr_i) begin
        vcode_o <= wdata_i[5:0];
      end
    end
  end

  // Enable follows edges of the on bit and drops on kill_i
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_prev <= 1'b0;
      pending <= 1'b0;
      en_o    <= 1'b0;
      cnt     <= 32'h0;
    end else begin
      on_prev <= on_bit_o;
      if (kill_i) begin
        en_o    <= 1'b0;
        pending <= 1'b0;
      end else if (on_rise) begin
        pending <= 1'b1;
        cnt     <= dly_cycles(dly_o);
      end else if (on_fall) begin
        en_o    <= 1'b0;
        pending <= 1'b0;
      end else if (pending) begin
        if (cnt == 32'h0) begin
          en_o    <= 1'b1;
          pending <= 1'b0;
        end else begin
          cnt <= cnt - 32'h1;
        end
      end
    end
  end

  // Fault on power-good fall; set wins over read-clear
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pgood_d     <= 1'b0;
      fault_irq_o <= 1'b0;
    end else begin
      pgood_d <= pgood_i;
      if (fmask_o && pg_fall) begin
        fault_irq_o <= 1'b1;
      end else if (stat_rd_i) begin
        fault_irq_o <= 1'b0;
      end
    end
  end

endmodule // smbc_buck_slot

//--- inc/smbc_consts.vh
// Constants for the supply monitor and buck control block.
// Assumes inclusion by bare name from hdl/ sources.
`ifndef SMBC_CONSTS_VH
`define SMBC_CONSTS_VH

// Register word offsets
`define SMBC_ADDR_SYS        4'h0
`define SMBC_ADDR_STAT       4'h1
`define SMBC_ADDR_BUCK0_CTL  4'h4
`define SMBC_ADDR_BUCK0_VOUT 4'h5
`define SMBC_ADDR_BUCK0_STAT 4'h6
`define SMBC_ADDR_W          4

// System register fields
`define SMBC_SYS_LEV_LSB     0
`define SMBC_SYS_MODE_BIT    4
`define SMBC_SYS_MSK_BIT     5
`define SMBC_SYS_RESET       32'h00000017

// Buck control fields
`define SMBC_CTL_ON_BIT      0
`define SMBC_CTL_DLY_LSB     1
`define SMBC_CTL_MODE_BIT    4
`define SMBC_CTL_MSK_BIT     5
`define SMBC_VOUT_RESET      6'h00

// Timing
`define SMBC_CLK_HZ          40000000
`define SMBC_DLY_UNIT_MS     2
`define SMBC_DLY_UNIT_CYC    ((`SMBC_CLK_HZ / 1000) * `SMBC_DLY_UNIT_MS)

`endif

//--- test/smbc_buck_model.sv
// Behavioural power stage of the three bucks.
// Assumes enables and fault requests are synchronous to ref_clk_i.
`timescale 1ns/1ps
module smbc_buck_model (
  // Clock
  input  wire logic       ref_clk_i,
  // Enables and forced faults
  input  wire logic [2:0] en_i,
  input  wire logic [2:0] fault_i,
  // Power-good flags
  output wire logic [2:0] pgood_o
);
  logic [2:0] ramp = 3'h0;
  logic [2:0] good = 3'h0;
  // Good two cycles after enable, low one cycle after disable or fault
  always @(posedge ref_clk_i) begin
    ramp <= en_i & ~fault_i;
    good <= ramp & en_i & ~fault_i;
  end
  assign pgood_o = good;
endmodule // smbc_buck_model

//--- test/smbc_top_asserts.sv
// Checker for the supply monitor and buck control block.
// Assumes it is bound to smbc_top and sees only its ports.
`timescale 1ns/1ps
module smbc_top_asserts #(parameter NBUCK = 3) (
  // Clock and reset
  input wire logic               ref_clk_i,
  input wire logic               rst_n_i,
  // Register bus
  input wire logic [3:0]         avs_address_i,
  input wire logic               avs_read_i,
  input wire logic               avs_write_i,
  input wire logic [31:0]        avs_writedata_i,
  input wire logic [3:0]         avs_byteenable_i,
  input wire logic               avs_waitrequest_o,
  // Monitors and controls
  input wire logic               monitored_supply_low_i,
  input wire logic               over_temp_i,
  input wire logic [NBUCK-1:0]   buck_enable_o,
  input wire logic [NBUCK-1:0]   buck_force_pwm_o,
  input wire logic [6*NBUCK-1:0] output_voltage_code_o,
  input wire logic [3:0]         supply_threshold_select_o,
  input wire logic               irq_out_n_o,
  input wire logic               irq_out_n_oe_o
);
  logic sys_mode;
  logic sys_msk;
  logic wr_acc;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Shadow of response mode and supply mask
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sys_mode <= 1'h1;
      sys_msk  <= 1'h0;
      wr_acc   <= 1'h0;
    end else begin
      wr_acc <= avs_write_i && !avs_waitrequest_o;
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0 && avs_byteenable_i[0]) begin
        sys_mode <= avs_writedata_i[4];
        sys_msk  <= avs_writedata_i[5];
      end
    end
  end
  sequence wait_once;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  bus_wait_a: assert property ($rose(avs_read_i || avs_write_i) |-> wait_once)
    else $error("access without exactly one wait cycle");
  bus_idle_a: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("wait while idle");
  uv_irq_a: assert property ($rose(monitored_supply_low_i) && sys_mode && sys_msk
    |-> ##[1:3] !irq_out_n_oe_o) else $error("no supply interrupt");
  uv_off_a: assert property ($rose(monitored_supply_low_i) && !sys_mode
    |-> ##[1:3] buck_enable_o == '0) else $error("no undervoltage shutdown");
  temp_off_a: assert property (over_temp_i [*3] |-> buck_enable_o == '0)
    else $error("buck on while hot");
  irq_hold_a: assert property (!irq_out_n_oe_o && !avs_read_i && !avs_write_i
    |=> !irq_out_n_oe_o) else $error("interrupt dropped without access");
  cfg_stable_a: assert property ($changed({buck_force_pwm_o, output_voltage_code_o,
    supply_threshold_select_o}) |-> wr_acc) else $error("setting changed without write");
  irq_drive_a: assert property (irq_out_n_o == 1'h0)
    else $error("interrupt pin drives high");
endmodule // smbc_top_asserts
bind smbc_top smbc_top_asserts #(.NBUCK(NBUCK)) i_chk (
  .ref_clk_i                 (ref_clk_i),
  .rst_n_i                   (rst_n_i),
  .avs_address_i             (avs_address_i),
  .avs_read_i                (avs_read_i),
  .avs_write_i               (avs_write_i),
  .avs_writedata_i           (avs_writedata_i),
  .avs_byteenable_i          (avs_byteenable_i),
  .avs_waitrequest_o         (avs_waitrequest_o),
  .monitored_supply_low_i    (monitored_supply_low_i),
  .over_temp_i               (over_temp_i),
  .buck_enable_o             (buck_enable_o),
  .buck_force_pwm_o          (buck_force_pwm_o),
  .output_voltage_code_o     (output_voltage_code_o),
  .supply_threshold_select_o (supply_threshold_select_o),
  .irq_out_n_o               (irq_out_n_o),
  .irq_out_n_oe_o            (irq_out_n_oe_o)
);

//--- test/supply_monitor_buck_control_test.sv
// Bench for the supply monitor and buck control block.
// Assumes the bound checker and a delay unit of 10 cycles.
`timescale 1ns/1ps
`define CHK(g, w) begin checks_done++; if ((g) !== (w)) begin mismatches++; \
  $display("BAD %0t got %h want %h", $time, g, w); end end
module supply_monitor_buck_control_test;
  typedef struct {logic [3:0] a, be; logic [31:0] d, e;} smbc_row_t;
  logic ref_clk_i = 1'h0, rst_n_i = 1'h0, avs_read_i = 1'h0, avs_write_i = 1'h0;
  logic monitored_supply_low_i = 1'h0, over_temp_i = 1'h0;
  logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hF, supply_threshold_select_o;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rdq;
  logic [2:0] buck_pgood_i, buck_enable_o, buck_force_pwm_o, fault = 3'h0;
  logic [17:0] output_voltage_code_o;
  logic avs_waitrequest_o, irq_out_n_o, irq_out_n_oe_o;
  integer mismatches = 0, checks_done = 0;
  smbc_row_t rows[7] = '{'{4'h5, 4'hF, 32'h3F, 32'h3F}, '{4'h9, 4'hF, 32'h2A, 32'h2A},
    '{4'hD, 4'hF, 32'h15, 32'h15}, '{4'h5, 4'h0, 32'h01, 32'h3F}, '{4'hE, 4'hF, 32'hFF, 32'h0},
    '{4'h3, 4'hF, 32'hFF, 32'h0}, '{4'hC, 4'hF, 32'h10, 32'h10}};
  smbc_top #(.UNIT_CYC(10)) i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .monitored_supply_low_i(monitored_supply_low_i), .over_temp_i(over_temp_i),
    .buck_pgood_i(buck_pgood_i), .buck_enable_o(buck_enable_o),
    .buck_force_pwm_o(buck_force_pwm_o), .output_voltage_code_o(output_voltage_code_o),
    .supply_threshold_select_o(supply_threshold_select_o), .irq_out_n_o(irq_out_n_o),
    .irq_out_n_oe_o(irq_out_n_oe_o));
  smbc_buck_model i_pm (.ref_clk_i(ref_clk_i), .en_i(buck_enable_o), .fault_i(fault),
    .pgood_o(buck_pgood_i));
  always #12.5 ref_clk_i = ~ref_clk_i;
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= rd;
    avs_write_i <= !rd;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'h0);
    rdq = avs_readdata_o;
    avs_read_i <= 1'h0;
    avs_write_i <= 1'h0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    mismatches++;
    wrap_up;
  end
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    cyc(1);
    `CHK(irq_out_n_oe_o, 1'h1)
    `CHK(supply_threshold_select_o, 4'h7)
    bus(1, 4'h0, 32'h0);
    `CHK(rdq, 32'h17)
    foreach (rows[i]) begin
      avs_byteenable_i <= rows[i].be;
      bus(0, rows[i].a, rows[i].d);
      avs_byteenable_i <= 4'hF;
      bus(1, rows[i].a, 32'h0);
      `CHK(rdq, rows[i].e)
    end
    cyc(1);
    `CHK(output_voltage_code_o, {6'h15, 6'h2A, 6'h3F})
    `CHK(buck_force_pwm_o, 3'h4)
    bus(0, 4'h8, 32'h4);
    bus(0, 4'h8, 32'h5);
    cyc(15);
    `CHK(buck_enable_o[1], 1'h0)
    cyc(15);
    `CHK(buck_enable_o[1], 1'h1)
    bus(0, 4'h4, 32'h1);
    bus(0, 4'h4, 32'h21);
    cyc(5);
    `CHK(buck_enable_o, 3'h3)
    @(posedge ref_clk_i) fault <= 3'h1;
    cyc(10);
    `CHK(irq_out_n_oe_o, 1'h0)
    bus(1, 4'h6, 32'h0);
    `CHK(rdq[1:0], 2'h2)
    cyc(2);
    `CHK(irq_out_n_oe_o, 1'h1)
    @(posedge ref_clk_i) fault <= 3'h0;
    bus(0, 4'h0, 32'h37);
    @(posedge ref_clk_i) monitored_supply_low_i <= 1'h1;
    cyc(5);
    `CHK(irq_out_n_oe_o, 1'h0)
    bus(1, 4'h1, 32'h0);
    `CHK(rdq[0], 1'h1)
    @(posedge ref_clk_i) monitored_supply_low_i <= 1'h0;
    cyc(3);
    `CHK(irq_out_n_oe_o, 1'h0)
    bus(1, 4'h1, 32'h0);
    `CHK(rdq[0], 1'h0)
    cyc(2);
    `CHK(irq_out_n_oe_o, 1'h1)
    bus(0, 4'h0, 32'h7);
    @(posedge ref_clk_i) monitored_supply_low_i <= 1'h1;
    cyc(5);
    `CHK(buck_enable_o, 3'h0)
    @(posedge ref_clk_i) monitored_supply_low_i <= 1'h0;
    bus(0, 4'h4, 32'h0);
    bus(0, 4'h4, 32'h1);
    @(posedge ref_clk_i) over_temp_i <= 1'h1;
    cyc(5);
    `CHK(buck_enable_o, 3'h0)
    bus(0, 4'h4, 32'h0);
    bus(0, 4'h4, 32'h1);
    @(posedge ref_clk_i) over_temp_i <= 1'h0;
    cyc(5);
    `CHK(buck_enable_o, 3'h0)
    bus(0, 4'h4, 32'h0);
    bus(0, 4'h4, 32'h1);
    cyc(5);
    `CHK(buck_enable_o, 3'h1)
    bus(0, 4'h4, 32'h0);
    cyc(5);
    `CHK(buck_enable_o, 3'h0)
    wrap_up;
  end
endmodule // supply_monitor_buck_control_test
